/* awu_defs.svh */
// Function
// - halt with enable enters timed wake mode
// - rc clock divided by 64 then prescale
// - expiry sets flag and wake interrupt
// - main oscillator restarts, 256 cycle delay
// - status read clears flag and request
// - flag writes ignored, hardware sets only
// - measure bit routes rc clock to capture
// - halt wake enable bit zero, software owned
// - prescale value is factor, zero forbidden
// - zero write leaves prescale unchanged
// - entry forces interrupt mask to zero
// - main clock stopped, peripherals unclocked
// - any halt capable interrupt or reset exits
// - watchdog option picks reset or halt entry
// - status bits 7:3 read zero
// - reset prescale ff, status zero
// - without enable, plain halt mode
`ifndef AWU_DEFS_SVH
`define AWU_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define AWU_PRESCALE_IDX    8'h49
`define AWU_CSR_IDX         8'h4a
`define AWU_IRQ_STAT_IDX    8'h4b
`define AWU_IRQ_MASK_IDX    8'h4c
`define AWU_PRESCALE_RST    8'hff
`define AWU_CSR_RST         8'h00

// ----------------------------------------
// fields
// ----------------------------------------
`define AWU_BIT_EN          0
`define AWU_BIT_MEAS        1
`define AWU_BIT_FLAG        2

// ----------------------------------------
// timing
// ----------------------------------------
`define AWU_FIX_DIV         64
`define AWU_STAB_CYCLES     256

`endif

/* awu_pkg.sv */
package awu_pkg;
    typedef enum logic [1:0] {
        AWU_RUN   = 2'b00,
        AWU_HALT  = 2'b01,
        AWU_TIMED = 2'b10,
        AWU_STAB  = 2'b11
    } awu_state_t;
endpackage

/* awu_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "awu_defs.svh"
module awu_divider (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       rcTick,
    input  wire logic [7:0] prescale,
    output logic            expire
);
    logic [5:0] fixCnt;
    logic [7:0] preCnt;
    wire        fixWrap = rcTick && (fixCnt == 6'(`AWU_FIX_DIV - 1));
    wire        preWrap = fixWrap && (preCnt >= prescale - 8'h01);

    // ----------------------------------------
    // divide by 64 then by prescale
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n || !run) begin
            fixCnt <= 6'h00;
            preCnt <= 8'h00;
            expire <= 1'b0;
        end else begin
            expire <= preWrap;
            if (rcTick)
                fixCnt <= fixCnt + 6'h01;
            if (fixWrap)
                preCnt <= preWrap ? 8'h00 : preCnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* awu_stab_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "awu_defs.svh"
module awu_stab_timer (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      done
);
    logic [8:0] cnt;
    // ----------------------------------------
    // oscillator settling count
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt  <= 9'h000;
            done <= 1'b0;
        end else if (start) begin
            cnt  <= 9'(`AWU_STAB_CYCLES - 1);
            done <= 1'b0;
        end else if (cnt != 9'h000) begin
            cnt  <= cnt - 9'h001;
            done <= (cnt == 9'h001);
        end else begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* awu_wake_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "awu_defs.svh"
module awu_wake_timer (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // cpu side
    input  wire logic        haltExec,
    input  wire logic        haltIrq,
    input  wire logic        watchdogEnabled,
    input  wire logic        watchdogHaltOption,
    input  wire logic        wakeRcTick,
    output logic             wakeRcEnable,
    output logic             captureInput,
    output logic             mainOscEnable,
    output logic             periphClockEnable,
    output logic             clearIntMask,
    output logic             cpuResume,
    output logic             watchdogReset,
    output logic             timedHaltWakeMode,
    output logic             wakeIrq,
    output logic             irq
);
    logic [7:0] wakePrescaleValue;
    logic       haltWakeEnable;
    logic       oscMeasureEnable;
    logic       wakeTimeoutFlag;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic       inTimed;
    awu_pkg::awu_state_t state;
    awu_pkg::awu_state_t next_state;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire       access  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       lane0   = wb_sel_i[0];
    wire       wrEn    = access && wb_we_i && lane0;
    wire       rdEn    = access && !wb_we_i;
    // index is the byte address: a scaled index would not fit 8 address bits
    wire       selPre  = wb_adr_i == `AWU_PRESCALE_IDX;
    wire       selCsr  = wb_adr_i == `AWU_CSR_IDX;
    wire       selStat = wb_adr_i == `AWU_IRQ_STAT_IDX;
    wire       selMask = wb_adr_i == `AWU_IRQ_MASK_IDX;
    wire       csrRead = rdEn && selCsr;
    wire [7:0] csrView = {5'h00, wakeTimeoutFlag, oscMeasureEnable,
                          haltWakeEnable};
    wire [7:0] rdMux   = selPre  ? wakePrescaleValue :
                         selCsr  ? csrView :
                         selStat ? {6'h00, irqStat} :
                         selMask ? {6'h00, irqMask} : 8'h00;

    // ----------------------------------------
    // halt sequencing
    // ----------------------------------------
    wire expire;
    wire stabDone;
    wire zeroPre    = wakePrescaleValue == 8'h00;
    wire wdBlock    = watchdogEnabled && !watchdogHaltOption;
    wire haltGo     = haltExec && (state == awu_pkg::AWU_RUN) && !wdBlock;
    wire timedEnter = haltGo && haltWakeEnable;
    wire expEvent   = inTimed && (expire || zeroPre);
    wire leaveHalt  = (state == awu_pkg::AWU_HALT ||
                       state == awu_pkg::AWU_TIMED) && (haltIrq || expEvent);

    always_comb begin
        next_state = state;
        unique case (state)
            awu_pkg::AWU_RUN:   if (haltGo)
                next_state = haltWakeEnable ? awu_pkg::AWU_TIMED
                                            : awu_pkg::AWU_HALT;
            awu_pkg::AWU_HALT:  if (leaveHalt) next_state = awu_pkg::AWU_STAB;
            awu_pkg::AWU_TIMED: if (leaveHalt) next_state = awu_pkg::AWU_STAB;
            awu_pkg::AWU_STAB:  if (stabDone) next_state = awu_pkg::AWU_RUN;
        endcase
    end

    assign inTimed           = state == awu_pkg::AWU_TIMED;
    assign timedHaltWakeMode = inTimed;
    // main clock off in either halt state; awu logic runs on the rc tick
    assign mainOscEnable     = !(state == awu_pkg::AWU_HALT || inTimed);
    assign periphClockEnable = state == awu_pkg::AWU_RUN;
    assign clearIntMask      = haltGo;
    assign cpuResume         = stabDone;
    assign watchdogReset     = haltExec && (state == awu_pkg::AWU_RUN) && wdBlock;
    assign wakeRcEnable      = inTimed || (oscMeasureEnable && state == awu_pkg::AWU_RUN);
    assign captureInput      = oscMeasureEnable && state == awu_pkg::AWU_RUN
                               && wakeRcTick;
    assign wakeIrq           = wakeTimeoutFlag;
    assign irq               = |(irqStat & irqMask);

    awu_divider u_div (
        .clock    (clock),
        .rst_n    (rst_n),
        .run      (inTimed),
        .rcTick   (wakeRcTick),
        .prescale (wakePrescaleValue),
        .expire   (expire)
    );

    awu_stab_timer u_stab (
        .clock (clock),
        .rst_n (rst_n),
        .start (leaveHalt),
        .done  (stabDone)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state             <= awu_pkg::AWU_RUN;
            wakePrescaleValue <= `AWU_PRESCALE_RST;
            haltWakeEnable    <= 1'b0;
            oscMeasureEnable  <= 1'b0;
            wb_ack_o          <= 1'b0;
            wb_dat_o          <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            wb_ack_o <= access;
            wb_dat_o <= rdEn ? {24'h00_0000, rdMux} : 32'h0000_0000;
            // zero ignored, product keeps old value
            if (wrEn && selPre && wb_dat_i[7:0] != 8'h00)
                wakePrescaleValue <= wb_dat_i[7:0];
            if (wrEn && selCsr) begin
                haltWakeEnable   <= wb_dat_i[`AWU_BIT_EN];
                oscMeasureEnable <= wb_dat_i[`AWU_BIT_MEAS];
            end
        end
    end

    // set beats the read-clear so no expiry is lost
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wakeTimeoutFlag <= 1'b0;
            irqStat         <= 2'b00;
            irqMask         <= 2'b00;
        end else begin
            if (expEvent)
                wakeTimeoutFlag <= 1'b1;
            else if (csrRead)
                wakeTimeoutFlag <= 1'b0;
            irqStat <= (irqStat & ~((wrEn && selStat) ? wb_dat_i[1:0] : 2'b00))
                       | {stabDone, expEvent};
            if (wrEn && selMask)
                irqMask <= wb_dat_i[1:0];
        end
    end
endmodule
`default_nettype wire

/* awu_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "awu_defs.svh"
module awu_props (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic       wb_ack_o,
    input wire logic       haltExec,
    input wire logic       clearIntMask,
    input wire logic       timedHaltWakeMode,
    input wire logic       wakeRcEnable,
    input wire logic       mainOscEnable,
    input wire logic       periphClockEnable,
    input wire logic       wakeIrq,
    input wire logic       cpuResume
);
    // ----------------------------------------
    // halt and bus checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire rdCsr = wb_ack_o && !wb_we_i && wb_adr_i == `AWU_CSR_IDX;
    sequence sExit; $fell(timedHaltWakeMode); endsequence
    // slack of a few cycles around the 256 count for the exit handshake
    sequence sResume; ##[250:262] cpuResume; endsequence
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    AST_ACK1: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_ENTRY: assert property ($rose(timedHaltWakeMode) |-> $past(haltExec))
        else $error("entry without halt");
    AST_MASK: assert property ($rose(timedHaltWakeMode) |-> $past(clearIntMask))
        else $error("mask not cleared");
    AST_HALT: assert property (timedHaltWakeMode |-> wakeRcEnable
        && !mainOscEnable && !periphClockEnable) else $error("clocks in halt");
    AST_EXPIRE: assert property ($rose(wakeIrq) |-> !periphClockEnable)
        else $error("flag set in run");
    AST_RESUME: assert property (sExit |-> sResume) else $error("resume late");
    AST_RDCLR: assert property (rdCsr && !timedHaltWakeMode |=> !wakeIrq)
        else $error("flag kept after read");
endmodule
`default_nettype wire

/* awu_rc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module awu_rc_model #(
    parameter int PERIOD = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wakeRcEnable,
    output logic     wakeRcTick
);
    logic [3:0] count;
    // oscillator stands still unless enabled, so no stray ticks
    always_ff @(posedge clock) begin
        if (!rst_n || !wakeRcEnable) begin
            count <= 4'h0;
            wakeRcTick <= 1'b0;
        end else begin
            count <= (count == PERIOD - 1) ? 4'h0 : count + 4'h1;
            wakeRcTick <= (count == PERIOD - 1);
        end
    end
endmodule
`default_nettype wire

/* awu_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "awu_defs.svh"
module testbench;
    logic        clock = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, haltExec = 1'b0, haltIrq = 1'b0, watchdogEnabled = 1'b0;
    logic        watchdogHaltOption = 1'b0, wb_ack_o, wakeRcTick, wakeRcEnable, irq;
    logic        captureInput, mainOscEnable, periphClockEnable, clearIntMask, cpuResume;
    logic        watchdogReset, timedHaltWakeMode, wakeIrq;
    logic [7:0]  wb_adr_i = 8'h00, rnd;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, expQ[$];
    int          fails = 0, comparisons = 0, seed = 46, capCount = 0;
    awu_wake_timer u_dut (.*);
    awu_rc_model u_rc (.clock(clock), .rst_n(rst_n), .wakeRcEnable(wakeRcEnable),
        .wakeRcTick(wakeRcTick));
    initial forever #2.5 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin @(posedge clock); n++; end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) fails++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back({24'h0, e});
        wb(1'b0, a, 8'h00);
    endtask
    task automatic halt();
        haltExec <= 1'b1;
        @(posedge clock);
        haltExec <= 1'b0;
    endtask
    task automatic waitResume();
        int n = 0;
        while (cpuResume !== 1'b1 && n < 3000) begin @(posedge clock); n++; end
        if (n >= 3000) fails++;
    endtask
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o, expQ.pop_front());
    initial begin #100000; fails++; stop_test(); end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rd(`AWU_PRESCALE_IDX, 8'hff);
        rd(`AWU_CSR_IDX, 8'h00);
        rd(8'h00, 8'h00);
        wb(1'b1, `AWU_PRESCALE_IDX, 8'h00);
        rd(`AWU_PRESCALE_IDX, 8'hff);
        rnd = 8'($random(seed)) | 8'h01;
        wb(1'b1, `AWU_PRESCALE_IDX, rnd);
        rd(`AWU_PRESCALE_IDX, rnd);
        wb(1'b1, `AWU_PRESCALE_IDX, 8'h01);
        wb(1'b1, `AWU_CSR_IDX, 8'hff);
        rd(`AWU_CSR_IDX, 8'h03);
        repeat (30) begin @(posedge clock); if (captureInput === 1'b1) capCount++; end
        chk(capCount, 32'd10);
        wb(1'b1, `AWU_CSR_IDX, 8'h01);
        wb(1'b1, `AWU_IRQ_MASK_IDX, 8'h01);
        halt();
        waitResume();
        chk({31'h0, irq}, 32'h1);
        rd(`AWU_CSR_IDX, 8'h05);
        rd(`AWU_CSR_IDX, 8'h01);
        wb(1'b1, `AWU_IRQ_STAT_IDX, 8'h03);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, `AWU_IRQ_MASK_IDX, 8'h00);
        wb(1'b1, `AWU_CSR_IDX, 8'h00);
        watchdogEnabled <= 1'b1;
        halt();
        chk({31'h0, watchdogReset}, 32'h1);
        @(posedge clock);
        chk({31'h0, mainOscEnable}, 32'h1);
        watchdogHaltOption <= 1'b1;
        halt();
        repeat (30) @(posedge clock);
        chk({31'h0, mainOscEnable}, 32'h0);
        haltIrq <= 1'b1;
        waitResume();
        haltIrq <= 1'b0;
        chk({31'h0, irq}, 32'h0);
        rd(`AWU_IRQ_STAT_IDX, 8'h02);
        stop_test();
    end
endmodule
bind awu_wake_timer awu_props u_props (.*);
`default_nettype wire
